/* File: rmis_params.svh */
/*
 * Constants for the remappable input select block: register offsets,
 * field layout, reset values and select codes.
 * Assumes a 32-bit Avalon-MM register bus with word addresses in bytes.
 */
`ifndef RMIS_PARAMS_SVH
`define RMIS_PARAMS_SVH

`define RMIS_NUM_PINS 16
`define RMIS_CODE_W 5
`define RMIS_CAP7_OFS 4'h0
`define RMIS_FLTA_OFS 4'h4
`define RMIS_CODE_LSB 0
`define RMIS_CODE_MSB 4
`define RMIS_CODE_RST 5'h1f
`define RMIS_CODE_GND 5'h1f
`define RMIS_CODE_MAXPIN 5'h0f
`define RMIS_ZERO_32 32'h0000_0000
`define RMIS_BAD_RESP 2'h2
`define RMIS_OK_RESP 2'h0

`endif

/* File: rmis_pkg.sv */
/*
 * Types shared by the remappable input select block.
 * Assumes the params header is included by each user file.
 */
package rmis_pkg;
   typedef logic [4:0] rmis_code_t;
   // One bus request as seen by the register file
   typedef struct packed {
      logic [3:0] addr;
      logic rd;
      logic wr;
      logic [31:0] wdata;
      logic [3:0] be;
   } rmis_req_s;
   typedef enum logic [0:0] {
      RMIS_IDLE = 1'b0,
      RMIS_RESP = 1'b1
   } rmis_state_e;
endpackage

/* File: rmis_sel_mux.sv */
/*
 * One selection multiplexer: picks a remappable pin by code or ground.
 * Assumes pin inputs are synchronous to the system clock.
 */
`include "rmis_params.svh"

module rmis_sel_mux (
   input wire logic [15:0] i_pins,
   input wire rmis_pkg::rmis_code_t i_code,
   output logic o_sel
);
   // All-ones ties low, low codes pick the pin, other codes also read low
   always_comb begin
      if (i_code == `RMIS_CODE_GND) begin
         o_sel = 1'b0;
      end else if (i_code <= `RMIS_CODE_MAXPIN) begin
         o_sel = i_pins[i_code[3:0]];
      end else begin
         o_sel = 1'b0;
      end
   end
endmodule

/* File: rmis_code_reg.sv */
/*
 * One five-bit selection code register with byte-lane write.
 * Assumes the caller decodes the address into a write strobe.
 */
`include "rmis_params.svh"

module rmis_code_reg (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_wr,
   input wire logic [4:0] i_wdata,
   output rmis_pkg::rmis_code_t o_code
);
   rmis_pkg::rmis_code_t code_q;
   rmis_pkg::rmis_code_t code_d;

   // Next code: takes the written value, else holds
   always_comb begin
      code_d = code_q;
      if (i_wr) begin
         code_d = i_wdata;
      end
   end

   // Resets to the ground code so no pin drives a peripheral at start
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         code_q <= `RMIS_CODE_RST;
      end else begin
         code_q <= code_d;
      end
   end

   assign o_code = code_q;
endmodule

/* File: rmis_top.sv */
/*
 * Remappable input select: two code registers on Avalon-MM steer
 * remappable pins onto the capture channel seven input and the compare
 * group A fault input.
 * Assumes pins are already synchronous to i_sys_clk; one clock domain.
 */
`include "rmis_params.svh"

// What this block does
// - Register ten holds a five-bit pin code in bits 4-0 for capture seven.
// - The all-ones code ties the chosen peripheral input to ground.
// - Codes 0 to 15 connect the input to the pin with that index.
// - Unused bits of both select registers read as zero.
// - Register eleven holds a five-bit code in bits 4-0 for fault A.
module rmis_top (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   output logic [1:0] o_avs_response,
   input wire logic [15:0] i_remappable_pin_n,
   output logic o_capture_channel_seven,
   output logic o_compare_group_a_fault
);
   rmis_pkg::rmis_req_s req;
   rmis_pkg::rmis_state_e state_q;
   rmis_pkg::rmis_state_e state_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic [1:0] resp_q;
   logic [1:0] resp_d;
   logic hit_cap7;
   logic hit_flta;
   logic wr_cap7;
   logic wr_flta;
   rmis_pkg::rmis_code_t capture_seven_pin_code;
   rmis_pkg::rmis_code_t compare_fault_a_pin_code;

   // Bundle the bus request
   always_comb begin
      req.addr = i_avs_address;
      req.rd = i_avs_read;
      req.wr = i_avs_write;
      req.wdata = i_avs_writedata;
      req.be = i_avs_byteenable;
   end

   // Address decode
   always_comb begin
      hit_cap7 = 1'b0;
      hit_flta = 1'b0;
      if (req.addr == `RMIS_CAP7_OFS) begin
         hit_cap7 = 1'b1;
      end else if (req.addr == `RMIS_FLTA_OFS) begin
         hit_flta = 1'b1;
      end
   end

   // Write commits at the accept edge only, where waitrequest is low, so
   // a master that aborts during the wait cycle leaves the code unchanged
   assign wr_cap7 = req.wr && hit_cap7 && req.be[0] &&
      (state_q == rmis_pkg::RMIS_RESP);
   assign wr_flta = req.wr && hit_flta && req.be[0] &&
      (state_q == rmis_pkg::RMIS_RESP);

   rmis_code_reg u_cap7_reg (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_wr(wr_cap7),
      .i_wdata(req.wdata[`RMIS_CODE_MSB:`RMIS_CODE_LSB]),
      .o_code(capture_seven_pin_code)
   );

   rmis_code_reg u_flta_reg (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_wr(wr_flta),
      .i_wdata(req.wdata[`RMIS_CODE_MSB:`RMIS_CODE_LSB]),
      .o_code(compare_fault_a_pin_code)
   );

   // Mux outputs are combinational so a new code acts at once
   rmis_sel_mux u_cap7_mux (
      .i_pins(i_remappable_pin_n),
      .i_code(capture_seven_pin_code),
      .o_sel(o_capture_channel_seven)
   );

   rmis_sel_mux u_flta_mux (
      .i_pins(i_remappable_pin_n),
      .i_code(compare_fault_a_pin_code),
      .o_sel(o_compare_group_a_fault)
   );

   // Bus sequencer: one wait cycle, then answer with registered data
   always_comb begin
      state_d = state_q;
      rdata_d = rdata_q;
      resp_d = resp_q;
      case (state_q)
         rmis_pkg::RMIS_IDLE: begin
            if (req.rd || req.wr) begin
               state_d = rmis_pkg::RMIS_RESP;
               rdata_d = `RMIS_ZERO_32;
               resp_d = `RMIS_OK_RESP;
               if (hit_cap7) begin
                  rdata_d[`RMIS_CODE_MSB:`RMIS_CODE_LSB] =
                     capture_seven_pin_code;
               end else if (hit_flta) begin
                  rdata_d[`RMIS_CODE_MSB:`RMIS_CODE_LSB] =
                     compare_fault_a_pin_code;
               end else begin
                  resp_d = `RMIS_BAD_RESP; // Unmapped: slave error, zero data
               end
               if (req.wr) begin
                  rdata_d = `RMIS_ZERO_32;
               end
            end
         end
         rmis_pkg::RMIS_RESP: begin
            state_d = rmis_pkg::RMIS_IDLE;
         end
         default: begin
            state_d = rmis_pkg::RMIS_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         state_q <= rmis_pkg::RMIS_IDLE;
         rdata_q <= `RMIS_ZERO_32;
         resp_q <= `RMIS_OK_RESP;
      end else begin
         state_q <= state_d;
         rdata_q <= rdata_d;
         resp_q <= resp_d;
      end
   end

   // Waitrequest drops in the answer cycle; low when idle per Avalon
   assign o_avs_waitrequest = (req.rd || req.wr) &&
      (state_q == rmis_pkg::RMIS_IDLE);
   assign o_avs_readdata = rdata_q;
   assign o_avs_response = resp_q;

   // Assertions
   property p_ground_code;
      @(posedge i_sys_clk) disable iff (i_reset)
      (capture_seven_pin_code == `RMIS_CODE_GND) |->
         !o_capture_channel_seven;
   endproperty
   a_ground_code: assert property (p_ground_code)
      else $error("capture input not grounded");

   property p_pin_select;
      @(posedge i_sys_clk) disable iff (i_reset)
      (compare_fault_a_pin_code <= `RMIS_CODE_MAXPIN) |->
         o_compare_group_a_fault ==
         i_remappable_pin_n[compare_fault_a_pin_code[3:0]];
   endproperty
   a_pin_select: assert property (p_pin_select)
      else $error("fault input not following chosen pin");

   sequence s_wr_cap7;
      i_avs_write && !o_avs_waitrequest &&
         (i_avs_address == `RMIS_CAP7_OFS) && i_avs_byteenable[0];
   endsequence
   property p_cap7_write;
      @(posedge i_sys_clk) disable iff (i_reset)
      s_wr_cap7 |=> capture_seven_pin_code ==
         $past(i_avs_writedata[4:0]);
   endproperty
   a_cap7_write: assert property (p_cap7_write)
      else $error("capture code not written");

   property p_flta_write;
      @(posedge i_sys_clk) disable iff (i_reset)
      (i_avs_write && !o_avs_waitrequest &&
         (i_avs_address == `RMIS_FLTA_OFS) && i_avs_byteenable[0]) |=>
         compare_fault_a_pin_code == $past(i_avs_writedata[4:0]);
   endproperty
   a_flta_write: assert property (p_flta_write)
      else $error("fault code not written");

   property p_reserved_zero;
      @(posedge i_sys_clk) disable iff (i_reset)
      (i_avs_read && !o_avs_waitrequest) |->
         o_avs_readdata[31:5] == 27'h000_0000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved bits not zero");

   property p_read_code;
      @(posedge i_sys_clk) disable iff (i_reset)
      (i_avs_read && o_avs_waitrequest &&
         (i_avs_address == `RMIS_FLTA_OFS)) |=>
         o_avs_readdata[4:0] == $past(compare_fault_a_pin_code);
   endproperty
   a_read_code: assert property (p_read_code)
      else $error("fault code readback wrong");

   property p_live_mux;
      @(posedge i_sys_clk) disable iff (i_reset)
      ($changed(capture_seven_pin_code) &&
         capture_seven_pin_code <= `RMIS_CODE_MAXPIN) |->
         o_capture_channel_seven ==
         i_remappable_pin_n[capture_seven_pin_code[3:0]];
   endproperty
   a_live_mux: assert property (p_live_mux)
      else $error("mux did not follow new code");

   property p_one_wait;
      @(posedge i_sys_clk) disable iff (i_reset)
      ((i_avs_read || i_avs_write) && o_avs_waitrequest) |=>
         !o_avs_waitrequest;
   endproperty
   a_one_wait: assert property (p_one_wait)
      else $error("bus answer late");
endmodule

/* File: rmis_periph_sink.sv */
/*
 * Far-side model: capture and compare fault inputs that sample the
 * steered levels on the system clock.
 * Assumes one clock domain shared with the select block.
 */
module rmis_periph_sink (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_cap,
   input wire logic i_flt,
   output logic o_cap_q,
   output logic o_flt_q
);
   // Peripherals see the steered input only at a clock edge
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         o_cap_q <= 1'b0;
         o_flt_q <= 1'b0;
      end else begin
         o_cap_q <= i_cap;
         o_flt_q <= i_flt;
      end
   end
endmodule

/* File: rmis_top_tb.sv */
/*
 * Self-checking bench for the remappable input select block.
 * Assumes the params header and the package are compiled first.
 */
`include "rmis_params.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
   $display("[ERR] %s exp %h got %h", nm, e, g); fail_count++; end end

module rmis_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, rst, rd, wr, wt, cap, flt, cap_q, flt_q;
   logic [3:0] adr, be;
   logic [31:0] wd, rdat, rv;
   logic [15:0] pins;
   logic [1:0] rsp, r;
   int fail_count, samples_checked;

   rmis_top dut (.i_sys_clk(clk), .i_reset(rst), .i_avs_address(adr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
      .i_avs_byteenable(be), .o_avs_readdata(rdat),
      .o_avs_waitrequest(wt), .o_avs_response(rsp),
      .i_remappable_pin_n(pins), .o_capture_channel_seven(cap),
      .o_compare_group_a_fault(flt));
   rmis_periph_sink sink (.i_sys_clk(clk), .i_reset(rst), .i_cap(cap),
      .i_flt(flt), .o_cap_q(cap_q), .o_flt_q(flt_q));

   // Free-running 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // One Avalon transfer, held until waitrequest is sampled low; only the
   // watchdog ends a wait that never finishes
   task automatic acc(input logic w, input logic [3:0] a,
                      input logic [31:0] d, input logic [3:0] b);
      @(posedge clk);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= d;
      be <= b;
      do begin
         @(posedge clk);
      end while (wt !== 1'b0);
      rv = rdat;
      r = rsp;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Cuts a hang short; the tests need well under 1000 cycles
   initial begin
      #200000;
      fail_count++;
      report_and_stop();
   end

   initial begin
      rst = 1'b1;
      {rd, wr} = 2'b00;
      adr = 4'h0;
      wd = 32'h0000_0000;
      be = 4'hf;
      pins = 16'hffff;
      fail_count = 0;
      samples_checked = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      // Reset values read back as ground code with upper bits clear
      acc(1'b0, `RMIS_CAP7_OFS, 32'h0000_0000, 4'hf);
      `CHK("cap7 reset", 32'h0000_001f, rv)
      `CHK("cap7 reset rsp", `RMIS_OK_RESP, r)
      acc(1'b0, `RMIS_FLTA_OFS, 32'h0000_0000, 4'hf);
      `CHK("flta reset", 32'h0000_001f, rv)
      `CHK("flta reset rsp", `RMIS_OK_RESP, r)
      `CHK("cap at ground", 1'b0, cap)
      `CHK("flt at ground", 1'b0, flt)
      $display("test reset done");
      // Every pin code on both selectors, with reversed order on fault A
      for (int i = 0; i < 16; i++) begin
         acc(1'b1, `RMIS_CAP7_OFS, 32'hffff_ffe0 | i, 4'hf);
         acc(1'b1, `RMIS_FLTA_OFS, 32'h0000_000f - i, 4'hf);
         pins <= 16'h0001 << i;
         @(posedge clk);
         `CHK("cap pin high", 1'b1, cap)
         `CHK("flt other pin", 1'b0, flt)
         pins <= ~(16'h0001 << i);
         @(posedge clk);
         @(posedge clk);
         `CHK("cap pin low", 1'b0, cap)
         `CHK("flt pin high", 1'b1, flt)
         `CHK("sink cap", 1'b0, cap_q)
         `CHK("sink flt", 1'b1, flt_q)
         acc(1'b0, `RMIS_CAP7_OFS, 32'h0000_0000, 4'hf);
         `CHK("cap7 readback", 32'h0000_0000 | i, rv)
         `CHK("cap7 read rsp", `RMIS_OK_RESP, r)
         acc(1'b0, `RMIS_FLTA_OFS, 32'h0000_0000, 4'hf);
         `CHK("flta readback", 32'h0000_000f - i, rv)
      end
      $display("test pin codes done");
      // Ground code blocks a pin held high
      acc(1'b1, `RMIS_CAP7_OFS, 32'h0000_001f, 4'hf);
      acc(1'b1, `RMIS_FLTA_OFS, 32'h0000_001f, 4'hf);
      pins <= 16'hffff;
      @(posedge clk);
      `CHK("cap ground", 1'b0, cap)
      `CHK("flt ground", 1'b0, flt)
      $display("test ground done");
      // Refused writes and an unmapped address
      acc(1'b1, `RMIS_CAP7_OFS, 32'h0000_0003, 4'he);
      acc(1'b0, `RMIS_CAP7_OFS, 32'h0000_0000, 4'hf);
      `CHK("lane0 off", 32'h0000_001f, rv)
      acc(1'b1, 4'h8, 32'h0000_0003, 4'hf);
      `CHK("unmapped wr rsp", `RMIS_BAD_RESP, r)
      acc(1'b0, 4'h8, 32'h0000_0000, 4'hf);
      `CHK("unmapped rd", 32'h0000_0000, rv)
      `CHK("unmapped rd rsp", `RMIS_BAD_RESP, r)
      $display("test refusals done");
      // An undefined code stores as written but steers no pin
      acc(1'b1, `RMIS_CAP7_OFS, 32'h0000_0010, 4'hf);
      @(posedge clk);
      `CHK("cap undefined code", 1'b0, cap)
      acc(1'b0, `RMIS_CAP7_OFS, 32'h0000_0000, 4'hf);
      `CHK("cap7 undefined rb", 32'h0000_0010, rv)
      $display("test undefined code done");
      report_and_stop();
   end
endmodule
